/* File: hw/tsc_regs.sv */
// transmit hdlc config, block pointer and slot assigner indirect registers
// ****************************************************************
// Overview of operation
// - block data holds 9-bit next-block pointer
// - pointer reads written value until read completes
// - config write updates all bits together
// - no byte enables means no access
// - burst code only for one-block, limiting on
// - burst code plus one gives block limit
// - limiting off means one block per transfer
// - limiting on allows merging for the one-block transfer size only
// - order low sends lsb first
// - order high sends msb first
// - seven-bit stuffing forces last bit value
// - stuffed value ignored without seven-bit stuffing
// - slot select write triggers, captures channel data
// - 5-bit link number selects link
// - ram address is slot and link concatenated
// - direction 0 writes ram, 1 reads back
// - busy high from trigger until done
// - block select write starts block access
// - assigned flag gives slot to channel
// ****************************************************************
module tsc_regs (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // register port
  input wire logic regSel,
  input wire logic regWr,
  input wire logic [11:0] regAddr,
  input wire logic [3:0] byteLaneEnables,
  input wire logic [31:0] regWdata,
  output logic [31:0] regRdata,
  // dma burst sizing
  input wire logic [2:0] channelTransferSize,
  output logic [3:0] maxBlocksPerDma,
  output logic mergeAllowed,
  // serial octet shaping
  input wire logic [7:0] hostByte,
  input wire logic sevenBitStuffing,
  output logic [7:0] txSerialOrder,
  // provision lookup for the slot assigner
  input wire logic [4:0] lookupSlot,
  input wire logic [4:0] lookupLink,
  input wire logic [7:0] idleFill,
  input wire logic [7:0] slotData,
  output logic [7:0] txSlotByte,
  output logic [4:0] slotStream,
  // configuration view
  output tsc_pkg::tsc_cfg_t cfgOut
);
  import tsc_pkg::*;

  // ****************************************************************
  // decode
  // ****************************************************************
  logic anyLane;
  logic wrEn;
  logic blkSelWr;
  logic blkDataWr;
  logic cfgWr;
  logic slotSelWr;
  logic chanDataWr;
  assign anyLane = |byteLaneEnables;
  assign wrEn = regSel && regWr && anyLane;
  assign blkSelWr = wrEn && regAddr == OFS_BLK_SEL;
  assign blkDataWr = wrEn && regAddr == OFS_BLK_DATA;
  assign cfgWr = wrEn && regAddr == OFS_CFG;
  assign slotSelWr = wrEn && regAddr == OFS_SLOT_SEL;
  assign chanDataWr = wrEn && regAddr == OFS_OWNING_STREAM_ID_DATA;

  // ****************************************************************
  // configuration register
  // ****************************************************************
  tsc_cfg_t cfg_ff;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ff <= '{BURST_RST, 1'b0, 1'b0, 1'b0};
    end else if (cfgWr) begin
      // all fields at once, lanes not honoured
      cfg_ff <= '{regWdata[BURST_MSB:0], regWdata[BURST_ON_POS],
                  regWdata[MSBF_POS], regWdata[STUFF_POS]};
    end
  end
  assign cfgOut = cfg_ff;

  // ****************************************************************
  // block pointer engine
  // ****************************************************************
  logic [8:0] blkRam [BLK_DEPTH];
  logic [8:0] ptr_ff;
  logic rsv_ff;
  logic [8:0] blkNum_ff;
  logic blkDir_ff;
  tsc_acc_t blkSt_ff;
  tsc_acc_t nxt_blkSt;
  logic [1:0] blkCnt_ff;

  always_comb begin
    nxt_blkSt = blkSt_ff;
    case (blkSt_ff)
      ACC_IDLE: if (blkSelWr) nxt_blkSt = ACC_WAIT;
      ACC_WAIT: if (blkCnt_ff == 2'(ACC_CYCLES - 1)) nxt_blkSt = ACC_DONE;
      ACC_DONE: nxt_blkSt = ACC_IDLE;
      default: nxt_blkSt = ACC_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      blkSt_ff <= ACC_IDLE;
      blkCnt_ff <= 2'h0;
    end else begin
      blkSt_ff <= nxt_blkSt;
      blkCnt_ff <= (blkSt_ff == ACC_WAIT) ? blkCnt_ff + 2'h1 : 2'h0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      blkNum_ff <= PTR_RST;
      blkDir_ff <= 1'b0;
    end else if (blkSelWr && blkSt_ff == ACC_IDLE) begin
      blkNum_ff <= regWdata[PTR_MSB:0];
      blkDir_ff <= regWdata[DIR_POS];
    end
  end

  // ram has no reset; software initialises every pointer
  always_ff @(posedge core_clk) begin
    if (blkSt_ff == ACC_DONE && !blkDir_ff) begin
      blkRam[blkNum_ff] <= ptr_ff;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_ff <= PTR_RST;
      rsv_ff <= 1'b0;
    end else if (blkSt_ff == ACC_DONE && blkDir_ff) begin
      ptr_ff <= blkRam[blkNum_ff];
    end else if (blkDataWr && blkSt_ff == ACC_IDLE) begin
      ptr_ff <= regWdata[PTR_MSB:0];
      rsv_ff <= regWdata[RSV_POS];
    end
  end

  // ****************************************************************
  // channel provision engine
  // ****************************************************************
  tsc_slot_t slotMapRam [SLOT_MAP_DEPTH];
  tsc_slot_t chanData_ff;
  tsc_slot_t hold_ff;
  logic [9:0] slotMapAddr_ff;
  logic slotDir_ff;
  logic [4:0] slotTs_ff;
  logic [4:0] slotLink_ff;
  tsc_acc_t slotSt_ff;
  tsc_acc_t nxt_slotSt;
  logic [1:0] slotCnt_ff;

  function automatic logic [9:0] slotMapAddr(input logic [4:0] ts,
                                             input logic [4:0] lnk);
    slotMapAddr = {ts, lnk};
  endfunction

  always_comb begin
    nxt_slotSt = slotSt_ff;
    case (slotSt_ff)
      ACC_IDLE: if (slotSelWr) nxt_slotSt = ACC_WAIT;
      ACC_WAIT: if (slotCnt_ff == 2'(ACC_CYCLES - 1)) nxt_slotSt = ACC_DONE;
      ACC_DONE: nxt_slotSt = ACC_IDLE;
      default: nxt_slotSt = ACC_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      slotSt_ff <= ACC_IDLE;
      slotCnt_ff <= 2'h0;
    end else begin
      slotSt_ff <= nxt_slotSt;
      slotCnt_ff <= (slotSt_ff == ACC_WAIT) ? slotCnt_ff + 2'h1 : 2'h0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      slotTs_ff <= 5'h00;
      slotLink_ff <= 5'h00;
      slotDir_ff <= 1'b0;
      slotMapAddr_ff <= 10'h000;
      hold_ff <= OWNING_STREAM_ID_RST;
    end else if (slotSelWr && slotSt_ff == ACC_IDLE) begin
      slotTs_ff <= regWdata[TS_MSB:0];
      slotLink_ff <= regWdata[LINK_MSB:LINK_LSB];
      slotDir_ff <= regWdata[DIR_POS];
      slotMapAddr_ff <= slotMapAddr(regWdata[TS_MSB:0],
                                    regWdata[LINK_MSB:LINK_LSB]);
      hold_ff <= chanData_ff;
    end
  end

  always_ff @(posedge core_clk) begin
    if (slotSt_ff == ACC_DONE && !slotDir_ff) begin
      slotMapRam[slotMapAddr_ff] <= hold_ff;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      chanData_ff <= OWNING_STREAM_ID_RST;
    end else if (slotSt_ff == ACC_DONE && slotDir_ff) begin
      chanData_ff <= slotMapRam[slotMapAddr_ff];
    end else if (chanDataWr && slotSt_ff == ACC_IDLE) begin
      chanData_ff <= '{regWdata[ASSIGNED_POS], regWdata[OWNING_STREAM_ID_MSB:0]};
    end
  end

  // slot lookup for the transmit path
  tsc_slot_t lookEntry;
  assign lookEntry =
    slotMapRam[slotMapAddr(lookupSlot, lookupLink)];
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      txSlotByte <= 8'h00;
      slotStream <= 5'h00;
    end else begin
      // unowned slots carry the idle fill byte
      txSlotByte <= lookEntry.slotAssignedFlag ? slotData : idleFill;
      slotStream <= lookEntry.owningStreamId;
    end
  end

  // ****************************************************************
  // dma sizing and octet shaping
  // ****************************************************************
  // bit reversal kept out of the conditional, where streaming is illegal
  function automatic logic [7:0] revByte(input logic [7:0] b);
    revByte = 8'h00;
    for (int i = 0; i < 8; i++) begin
      revByte[i] = b[7 - i];
    end
  endfunction

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      maxBlocksPerDma <= BLOCKS_ONE;
      mergeAllowed <= 1'b0;
      txSerialOrder <= 8'h00;
    end else begin
      if (channelTransferSize == CHANNEL_TRANSFER_SIZE_ONE_BLOCK && cfg_ff.burstLimitOn) begin
        maxBlocksPerDma <= {1'b0, cfg_ff.burstLen} + 4'h1;
        mergeAllowed <= 1'b1;
      end else begin
        // other sizes, or limiting off, give one block and no merging
        maxBlocksPerDma <= BLOCKS_ONE;
        mergeAllowed <= 1'b0;
      end
      // bit 0 of the output is sent first on the line
      txSerialOrder <= cfg_ff.msbFirstOrder ?
        revByte(hostByte) : hostByte;
      if (sevenBitStuffing) begin
        txSerialOrder[7] <= cfg_ff.stuffedLsbValue;
      end
    end
  end

  // ****************************************************************
  // read back
  // ****************************************************************
  always_comb begin
    regRdata = 32'h0000_0000;
    if (regSel && !regWr && anyLane) begin
      case (regAddr)
        OFS_BLK_SEL: begin
          regRdata[BUSY_POS] = blkSt_ff != ACC_IDLE;
          regRdata[DIR_POS] = blkDir_ff;
          regRdata[PTR_MSB:0] = blkNum_ff;
        end
        OFS_BLK_DATA: begin
          regRdata[RSV_POS] = rsv_ff;
          regRdata[PTR_MSB:0] = ptr_ff;
        end
        OFS_CFG: begin
          regRdata[STUFF_POS] = cfg_ff.stuffedLsbValue;
          regRdata[MSBF_POS] = cfg_ff.msbFirstOrder;
          regRdata[BURST_ON_POS] = cfg_ff.burstLimitOn;
          regRdata[BURST_MSB:0] = cfg_ff.burstLen;
        end
        OFS_SLOT_SEL: begin
          regRdata[BUSY_POS] = slotSt_ff != ACC_IDLE;
          regRdata[DIR_POS] = slotDir_ff;
          regRdata[LINK_MSB:LINK_LSB] = slotLink_ff;
          regRdata[TS_MSB:0] = slotTs_ff;
        end
        OFS_OWNING_STREAM_ID_DATA: begin
          regRdata[ASSIGNED_POS] = chanData_ff.slotAssignedFlag;
          regRdata[OWNING_STREAM_ID_MSB:0] = chanData_ff.owningStreamId;
        end
        default: regRdata = 32'h0000_0000;
      endcase
    end
  end
endmodule // tsc_regs

/* File: common/tsc_pkg.sv */
// package: register map, field layout and types of the tx slot config block
package tsc_pkg;
  // register byte offsets
  localparam logic [11:0] OFS_BLK_SEL = 12'h3a0;
  localparam logic [11:0] OFS_BLK_DATA = 12'h3a4;
  localparam logic [11:0] OFS_CFG = 12'h3b0;
  localparam logic [11:0] OFS_SLOT_SEL = 12'h400;
  localparam logic [11:0] OFS_OWNING_STREAM_ID_DATA = 12'h404;
  // field positions
  localparam int BUSY_POS = 15;
  localparam int DIR_POS = 14;
  localparam int RSV_POS = 15;
  localparam int PTR_MSB = 8;
  localparam int BURST_MSB = 2;
  localparam int BURST_ON_POS = 7;
  localparam int MSBF_POS = 8;
  localparam int STUFF_POS = 9;
  localparam int LINK_LSB = 8;
  localparam int LINK_MSB = 12;
  localparam int TS_MSB = 4;
  localparam int ASSIGNED_POS = 8;
  localparam int OWNING_STREAM_ID_MSB = 4;
  // sizes and reset values
  localparam int BLK_DEPTH = 512;
  localparam int SLOT_MAP_DEPTH = 1024;
  localparam logic [2:0] CHANNEL_TRANSFER_SIZE_ONE_BLOCK = 3'h0;
  localparam logic [3:0] BLOCKS_ONE = 4'h1;
  localparam logic [8:0] PTR_RST = 9'h000;
  localparam logic [2:0] BURST_RST = 3'h0;
  localparam logic [5:0] OWNING_STREAM_ID_RST = 6'h00;
  // ram access latency in cycles
  localparam int ACC_CYCLES = 2;

  typedef struct packed {
    logic [2:0] burstLen;
    logic burstLimitOn;
    logic msbFirstOrder;
    logic stuffedLsbValue;
  } tsc_cfg_t;

  typedef struct packed {
    logic slotAssignedFlag;
    logic [4:0] owningStreamId;
  } tsc_slot_t;

  typedef enum logic [2:0] {
    ACC_IDLE = 3'b001,
    ACC_WAIT = 3'b010,
    ACC_DONE = 3'b100
  } tsc_acc_t;
endpackage

/* File: tb/tsc_regs_chk.sv */
// checker: port assertions for the tx slot config registers
module tsc_regs_chk
  import tsc_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // register port
  input wire logic regSel,
  input wire logic regWr,
  input wire logic [11:0] regAddr,
  input wire logic [3:0] byteLaneEnables,
  input wire logic [31:0] regWdata,
  input wire logic [31:0] regRdata,
  // datapath controls
  input wire logic [2:0] channelTransferSize,
  input wire logic [3:0] maxBlocksPerDma,
  input wire logic mergeAllowed,
  input wire logic [7:0] hostByte,
  input wire logic sevenBitStuffing,
  input wire logic [7:0] txSerialOrder,
  input wire tsc_cfg_t cfgOut
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************
  // helpers
  // ****************
  logic cfgWr, rd, lim;
  logic [5:0] cfgIn, cfgRd;
  assign cfgWr = regSel && regWr && regAddr == OFS_CFG;
  assign rd = regSel && !regWr;
  assign lim = cfgOut.burstLimitOn && channelTransferSize == CHANNEL_TRANSFER_SIZE_ONE_BLOCK;
  assign cfgIn = {regWdata[2:0], regWdata[7], regWdata[8], regWdata[9]};
  assign cfgRd = {regRdata[2:0], regRdata[7], regRdata[8], regRdata[9]};
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_cfg_wr;
    cfgWr && |byteLaneEnables |=> cfgOut == $past(cfgIn);
  endproperty
  a_cfg_wr: assert property (p_cfg_wr) else $error("cfg write lost");
  property p_cfg_hold;
    cfgWr && byteLaneEnables == 4'h0 |=> $stable(cfgOut);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("cfg changed");
  property p_rd_idle;
    rd && byteLaneEnables == 4'h0 |-> regRdata == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("no-lane read");
  property p_cfg_rd;
    rd && regAddr == OFS_CFG && |byteLaneEnables |-> cfgRd == cfgOut;
  endproperty
  a_cfg_rd: assert property (p_cfg_rd) else $error("cfg readback");
  property p_blocks;
    1'b1 |=> maxBlocksPerDma ==
      ($past(lim) ? $past(cfgOut.burstLen) + 4'h1 : BLOCKS_ONE);
  endproperty
  a_blocks: assert property (p_blocks) else $error("burst size");
  property p_merge;
    1'b1 |=> mergeAllowed == $past(lim);
  endproperty
  a_merge: assert property (p_merge) else $error("merge flag");
  property p_lsb;
    !sevenBitStuffing && !cfgOut.msbFirstOrder
      |=> txSerialOrder == $past(hostByte);
  endproperty
  a_lsb: assert property (p_lsb) else $error("lsb order");
  property p_msb;
    cfgOut.msbFirstOrder |=> txSerialOrder[0] == $past(hostByte[7]);
  endproperty
  a_msb: assert property (p_msb) else $error("msb order");
  property p_stuff;
    sevenBitStuffing |=> txSerialOrder[7] == $past(cfgOut.stuffedLsbValue);
  endproperty
  a_stuff: assert property (p_stuff) else $error("stuffed bit");
  c_nolane: cover property (cfgWr && byteLaneEnables == 4'h0);
  c_stuff: cover property (sevenBitStuffing && cfgOut.stuffedLsbValue);
  c_lim: cover property (lim && cfgOut.burstLen == 3'h7);
endmodule // tsc_regs_chk

bind tsc_regs tsc_regs_chk u_chk (.core_clk(core_clk), .rst_n(rst_n),
  .regSel(regSel), .regWr(regWr), .regAddr(regAddr),
  .byteLaneEnables(byteLaneEnables), .regWdata(regWdata),
  .regRdata(regRdata), .channelTransferSize(channelTransferSize),
  .maxBlocksPerDma(maxBlocksPerDma), .mergeAllowed(mergeAllowed),
  .hostByte(hostByte), .sevenBitStuffing(sevenBitStuffing),
  .txSerialOrder(txSerialOrder), .cfgOut(cfgOut));

/* File: tb/tb_top.sv */
// testbench: register sequences against the tx slot config block
module tb_top;
  import tsc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************
  // stimulus and checks
  // ****************
  logic core_clk, rst_n, regSel, regWr, mergeAllowed, stuf;
  logic [11:0] regAddr;
  logic [3:0] ble, maxBlk;
  logic [31:0] wd, rdata, q;
  logic [2:0] channel_transfer_size;
  logic [7:0] hb, ser, idleFill, slotData, slotByte;
  logic [4:0] lkSlot, lkLink, stream;
  tsc_cfg_t cfgOut;
  int numErrors = 0;
  int checksDone = 0;
  tsc_regs dut (.core_clk(core_clk), .rst_n(rst_n), .regSel(regSel),
    .regWr(regWr), .regAddr(regAddr), .byteLaneEnables(ble),
    .regWdata(wd), .regRdata(rdata), .channelTransferSize(channel_transfer_size),
    .maxBlocksPerDma(maxBlk), .mergeAllowed(mergeAllowed),
    .hostByte(hb), .sevenBitStuffing(stuf), .txSerialOrder(ser),
    .lookupSlot(lkSlot), .lookupLink(lkLink), .idleFill(idleFill),
    .slotData(slotData), .txSlotByte(slotByte), .slotStream(stream),
    .cfgOut(cfgOut));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic summarize();
    $display("errors %0d checks %0d", numErrors, checksDone);
    if (numErrors == 0 && checksDone > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checksDone++;
    if (g !== e) begin
      numErrors++;
      $display("FAIL t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // strobe held through the taking edge, read data sampled before it
  task automatic acc(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    @(negedge core_clk);
    regSel = 1'b1;
    regWr = w;
    regAddr = a;
    wd = d;
    ble = be;
    #5 q = rdata;
    @(negedge core_clk);
    regSel = 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    acc(1'b1, a, d, 4'hf);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0, 4'hf);
    chk(q, e);
  endtask
  task automatic waitIdle(input logic [11:0] a);
    int n;
    n = 0;
    q = 32'h8000;
    while (q[BUSY_POS] !== 1'b0 && n < 20) begin
      acc(1'b0, a, 32'h0, 4'hf);
      n++;
    end
    if (q[BUSY_POS] !== 1'b0) begin
      numErrors++;
      $display("FAIL t=%0t busy stuck", $time);
      summarize();
    end
  endtask
  task automatic sr(input logic [7:0] b, input logic s, input logic [7:0] e);
    @(negedge core_clk);
    hb = b;
    stuf = s;
    @(negedge core_clk);
    chk({24'h0, ser}, {24'h0, e});
  endtask
  initial begin
    rst_n = 1'b0;
    regSel = 1'b0;
    regWr = 1'b0;
    regAddr = 12'h0;
    ble = 4'h0;
    wd = 32'h0;
    channel_transfer_size = 3'h0;
    hb = 8'h0;
    stuf = 1'b0;
    lkSlot = 5'h0;
    lkLink = 5'h0;
    idleFill = 8'hee;
    slotData = 8'h5a;
    repeat (3) @(negedge core_clk);
    rst_n = 1'b1;
    chk({28'h0, maxBlk}, 32'h1);
    rdc(OFS_CFG, 32'h0);
    rdc(OFS_BLK_DATA, 32'h0);
    acc(1'b1, OFS_CFG, 32'h387, 4'h1);
    rdc(OFS_CFG, 32'h387);
    acc(1'b1, OFS_CFG, 32'h0, 4'h0);
    acc(1'b0, OFS_CFG, 32'h0, 4'h0);
    chk(q, 32'h0);
    rdc(OFS_CFG, 32'h387);
    rdc(12'h3a8, 32'h0);
    $display("test cfg done");
    for (int i = 0; i < 8; i++) begin
      wr(OFS_CFG, 32'h80 | i);
      @(negedge core_clk);
      chk({28'h0, maxBlk}, i + 1);
    end
    chk({31'h0, mergeAllowed}, 32'h1);
    channel_transfer_size = 3'h1;
    repeat (2) @(negedge core_clk);
    chk({27'h0, mergeAllowed, maxBlk}, 32'h1);
    channel_transfer_size = 3'h0;
    wr(OFS_CFG, 32'h7);
    @(negedge core_clk);
    chk({27'h0, mergeAllowed, maxBlk}, 32'h1);
    $display("test burst done");
    wr(OFS_CFG, 32'h100);
    sr(8'h01, 1'b0, 8'h80);
    sr(8'h03, 1'b1, 8'h40);
    wr(OFS_CFG, 32'h200);
    sr(8'h01, 1'b0, 8'h01);
    sr(8'h01, 1'b1, 8'h81);
    $display("test order done");
    wr(OFS_OWNING_STREAM_ID_DATA, 32'h115);
    wr(OFS_SLOT_SEL, 32'h305);
    rdc(OFS_SLOT_SEL, 32'h8305);
    waitIdle(OFS_SLOT_SEL);
    wr(OFS_OWNING_STREAM_ID_DATA, 32'h00a);
    wr(OFS_SLOT_SEL, 32'h503);
    waitIdle(OFS_SLOT_SEL);
    wr(OFS_OWNING_STREAM_ID_DATA, 32'h0);
    wr(OFS_SLOT_SEL, 32'h4305);
    wr(OFS_OWNING_STREAM_ID_DATA, 32'h01f);
    waitIdle(OFS_SLOT_SEL);
    rdc(OFS_OWNING_STREAM_ID_DATA, 32'h115);
    lkSlot = 5'h5;
    lkLink = 5'h3;
    repeat (2) @(negedge core_clk);
    chk({19'h0, stream, slotByte}, {19'h0, 5'h15, 8'h5a});
    lkSlot = 5'h3;
    lkLink = 5'h5;
    repeat (2) @(negedge core_clk);
    chk({24'h0, slotByte}, {24'h0, 8'hee});
    $display("test slot done");
    // two blocks linked into a closed ring: 0x002 -> 0x1a5 -> 0x002
    wr(OFS_BLK_DATA, 32'h1a5);
    wr(OFS_BLK_SEL, 32'h002);
    waitIdle(OFS_BLK_SEL);
    wr(OFS_BLK_DATA, 32'h002);
    wr(OFS_BLK_SEL, 32'h1a5);
    waitIdle(OFS_BLK_SEL);
    wr(OFS_BLK_DATA, 32'h033);
    rdc(OFS_BLK_DATA, 32'h033);
    wr(OFS_BLK_SEL, 32'h4002);
    rdc(OFS_BLK_SEL, 32'hc002);
    waitIdle(OFS_BLK_SEL);
    rdc(OFS_BLK_DATA, 32'h1a5);
    wr(OFS_BLK_SEL, 32'h41a5);
    waitIdle(OFS_BLK_SEL);
    rdc(OFS_BLK_DATA, 32'h002);
    $display("test block done");
    summarize();
  end
endmodule // tb_top
